// ==== aidt_pkg.sv ====
/*
 * Package for the arithmetic decode and timing block: opcode patterns,
 * clock counts, decoded classes and the carrier structs.
 * Assumes it is compiled before every module of the block.
 */
package aidt_pkg;

    // =========================================================================
    // Opcode patterns and masks
    // =========================================================================
    localparam logic [7:0] AIDT_OP_PFX_CODE    = 8'h2E;
    localparam logic [7:0] AIDT_OP_PFX_STACK   = 8'h36;
    localparam logic [7:0] AIDT_OP_PFX_DATA    = 8'h3E;
    localparam logic [7:0] AIDT_OP_PFX_EXTRA   = 8'h26;
    localparam logic [7:0] AIDT_MASK_RM        = 8'hFC;
    localparam logic [7:0] AIDT_OP_ADD_RM      = 8'h00;
    localparam logic [7:0] AIDT_OP_ADC_RM      = 8'h10;
    localparam logic [7:0] AIDT_OP_SUB_RM      = 8'h28;
    localparam logic [7:0] AIDT_OP_BORROW_RM   = 8'h18;
    localparam logic [7:0] AIDT_OP_IMM_GRP     = 8'h80;
    localparam logic [7:0] AIDT_MASK_W         = 8'hFE;
    localparam logic [7:0] AIDT_OP_UNARY_GRP   = 8'hF6;
    localparam logic [7:0] AIDT_OP_ASC_ADD     = 8'h37;
    localparam logic [7:0] AIDT_OP_ASC_SUB     = 8'h3F;
    localparam logic [7:0] AIDT_OP_DEC_ADD     = 8'h27;
    localparam logic [7:0] AIDT_OP_DEC_SUB     = 8'h2F;
    localparam logic [2:0] AIDT_SUB_SIGN       = 3'h3;
    localparam logic [2:0] AIDT_SUB_MULU       = 3'h4;
    localparam logic [2:0] AIDT_SUB_ADD        = 3'h0;
    localparam logic [2:0] AIDT_SUB_ADC        = 3'h2;
    localparam logic [2:0] AIDT_SUB_SUB        = 3'h5;
    localparam logic [2:0] AIDT_SUB_BORROW     = 3'h3;
    localparam logic [1:0] AIDT_MOD_REG        = 2'h3;

    // =========================================================================
    // Clock counts
    // =========================================================================
    localparam logic [5:0] AIDT_CLK_PREFIX     = 6'h02;
    localparam logic [5:0] AIDT_CLK_RM_REG     = 6'h03;
    localparam logic [5:0] AIDT_CLK_RM_MEM     = 6'h0A;
    localparam logic [5:0] AIDT_CLK_IMM_REG    = 6'h04;
    localparam logic [5:0] AIDT_CLK_IMM_MEM    = 6'h10;
    localparam logic [5:0] AIDT_CLK_ASC_ADD    = 6'h08;
    localparam logic [5:0] AIDT_CLK_ASC_SUB    = 6'h07;
    localparam logic [5:0] AIDT_CLK_DEC_ADJ    = 6'h04;
    localparam logic [5:0] AIDT_CLK_MPY_RB_MIN = 6'h1A;
    localparam logic [5:0] AIDT_CLK_MPY_RB_MAX = 6'h1C;
    localparam logic [5:0] AIDT_CLK_MPY_RW_MIN = 6'h23;
    localparam logic [5:0] AIDT_CLK_MPY_RW_MAX = 6'h25;
    localparam logic [5:0] AIDT_CLK_MPY_MB_MIN = 6'h20;
    localparam logic [5:0] AIDT_CLK_MPY_MB_MAX = 6'h22;
    localparam logic [5:0] AIDT_CLK_MPY_MW_MIN = 6'h29;
    localparam logic [5:0] AIDT_CLK_MPY_MW_MAX = 6'h2B;

    // =========================================================================
    // Reset values
    // =========================================================================
    localparam logic [1:0] AIDT_SEG_NONE_RST   = 2'h0;

    // =========================================================================
    // Types
    // =========================================================================
    typedef enum logic [3:0] {
        AIDT_ALU_NONE        = 4'h0,
        AIDT_ALU_ADD         = 4'h1,
        AIDT_ALU_ADC         = 4'h2,
        AIDT_ALU_SUB         = 4'h3,
        AIDT_ALU_BORROW      = 4'h4,
        AIDT_ALU_SIGN_CHANGE = 4'h5,
        AIDT_ALU_ASCII_ADD   = 4'h6,
        AIDT_ALU_ASCII_SUB   = 4'h7,
        AIDT_ALU_DECIMAL_ADD = 4'h8,
        AIDT_ALU_DECIMAL_SUB = 4'h9,
        AIDT_ALU_MULU        = 4'hA,
        AIDT_ALU_PREFIX      = 4'hB
    } aidt_op_t;

    typedef enum logic [1:0] {
        // Codes equal bits 4:3 of the prefix opcodes, so the decoder casts them.
        AIDT_SEG_CODE  = 2'h1,
        AIDT_SEG_STACK = 2'h2,
        AIDT_SEG_DATA  = 2'h3,
        AIDT_SEG_EXTRA = 2'h0
    } aidt_seg_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
        logic [7:0] modrm;
    } aidt_fetch_t;

    typedef struct packed {
        logic       valid;
        aidt_op_t   op;
        logic       is_word;
        logic       is_mem;
        logic       use_carry;
        logic       seg_valid;
        aidt_seg_t  seg;
        logic       imm_sext;
        logic [1:0] imm_bytes;
        logic [1:0] length;
        logic [5:0] clk_min;
        logic [5:0] clk_max;
        logic       known;
    } aidt_decode_t;

endpackage : aidt_pkg

// ==== aidt_imm_ext.sv ====
/*
 * Immediate operand shaper: widens a byte immediate to word width.
 * Assumes the data bytes come straight from the prefetch queue.
 */
`timescale 1ns/100ps

module aidt_imm_ext
    import aidt_pkg::*;
(
    input  wire logic        is_word,
    input  wire logic        sext,
    input  wire logic [7:0]  data_lo,
    input  wire logic [7:0]  data_hi,
    output logic      [15:0] imm
);

    // =========================================================================
    // Width selection
    // =========================================================================
    always_comb begin
        if (!is_word) begin
            imm = {8'h00, data_lo};
        end else if (sext) begin
            imm = {{8{data_lo[7]}}, data_lo};
        end else begin
            imm = {data_hi, data_lo};
        end
    end

endmodule : aidt_imm_ext

// ==== aidt_decode.sv ====
/*
 * Decoder and minimum/maximum clock-count table for the segment prefixes and the
 * integer arithmetic group.
 * Assumes opcode, mod byte and data bytes are presented together from the
 * prefetch queue, synchronous to clk_sys.
 */
`timescale 1ns/100ps

module aidt_decode
    import aidt_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire aidt_fetch_t  fetch,
    input  wire logic [7:0]   data_lo,
    input  wire logic [7:0]   data_hi,
    output aidt_decode_t      dec_reg,
    output logic      [15:0]  imm_reg
);

    // =========================================================================
    // Field extraction
    // =========================================================================
    logic [7:0]   op;
    logic [1:0]   mod_f;
    logic [2:0]   mid_f;
    logic         w_bit;
    logic         s_bit;
    logic         mem_f;
    aidt_decode_t dec_next;
    logic [15:0]  imm_next;
    aidt_seg_t    pend_seg_reg;
    logic         pend_valid_reg;

    assign op    = fetch.opcode;
    assign mod_f = fetch.modrm[7:6];
    assign mid_f = fetch.modrm[5:3];
    assign w_bit = op[0];
    assign s_bit = op[1];
    assign mem_f = (mod_f != AIDT_MOD_REG);

    aidt_imm_ext u_imm (
        .is_word (w_bit),
        .sext    (s_bit),
        .data_lo (data_lo),
        .data_hi (data_hi),
        .imm     (imm_next)
    );

    // =========================================================================
    // Decode table
    // =========================================================================
    always_comb begin
        dec_next           = '0;
        dec_next.valid     = fetch.valid;
        dec_next.is_word   = w_bit;
        dec_next.is_mem    = mem_f;
        dec_next.seg_valid = pend_valid_reg;
        dec_next.seg       = pend_seg_reg;
        dec_next.length    = 2'h1;
        dec_next.known     = 1'b1;
        if ((op & AIDT_MASK_RM) == AIDT_OP_ADD_RM) begin
            dec_next.op      = AIDT_ALU_ADD;
            dec_next.length  = 2'h2;
            dec_next.clk_min = mem_f ? AIDT_CLK_RM_MEM : AIDT_CLK_RM_REG;
        end else if ((op & AIDT_MASK_RM) == AIDT_OP_ADC_RM) begin
            dec_next.op        = AIDT_ALU_ADC;
            dec_next.use_carry = 1'b1;
            dec_next.length    = 2'h2;
            dec_next.clk_min   = mem_f ? AIDT_CLK_RM_MEM : AIDT_CLK_RM_REG;
        end else if ((op & AIDT_MASK_RM) == AIDT_OP_SUB_RM) begin
            dec_next.op      = AIDT_ALU_SUB;
            dec_next.length  = 2'h2;
            dec_next.clk_min = mem_f ? AIDT_CLK_RM_MEM : AIDT_CLK_RM_REG;
        end else if ((op & AIDT_MASK_RM) == AIDT_OP_BORROW_RM) begin
            dec_next.op        = AIDT_ALU_BORROW;
            dec_next.use_carry = 1'b1;
            dec_next.length    = 2'h2;
            dec_next.clk_min   = mem_f ? AIDT_CLK_RM_MEM : AIDT_CLK_RM_REG;
        end else if ((op & AIDT_MASK_RM) == AIDT_OP_IMM_GRP) begin
            // Only the add, carry-add, subtract and borrow rows belong here.
            dec_next.length    = 2'h2;
            dec_next.imm_sext  = s_bit & w_bit;
            dec_next.imm_bytes = (w_bit & ~s_bit) ? 2'h2 : 2'h1;
            dec_next.clk_min   = mem_f ? AIDT_CLK_IMM_MEM : AIDT_CLK_IMM_REG;
            dec_next.use_carry = (mid_f == AIDT_SUB_ADC) || (mid_f == AIDT_SUB_BORROW);
            if (mid_f == AIDT_SUB_ADD) begin
                dec_next.op = AIDT_ALU_ADD;
            end else if (mid_f == AIDT_SUB_ADC) begin
                dec_next.op = AIDT_ALU_ADC;
            end else if (mid_f == AIDT_SUB_SUB) begin
                dec_next.op = AIDT_ALU_SUB;
            end else if (mid_f == AIDT_SUB_BORROW) begin
                dec_next.op = AIDT_ALU_BORROW;
            end else begin
                dec_next.known   = 1'b0;
                dec_next.clk_min = 6'h00;
            end
        end else if ((op & AIDT_MASK_W) == AIDT_OP_UNARY_GRP) begin
            dec_next.length = 2'h2;
            if (mid_f == AIDT_SUB_SIGN) begin
                dec_next.op      = AIDT_ALU_SIGN_CHANGE;
                dec_next.clk_min = mem_f ? AIDT_CLK_RM_MEM : AIDT_CLK_RM_REG;
            end else if (mid_f == AIDT_SUB_MULU) begin
                dec_next.op = AIDT_ALU_MULU;
                unique case ({mem_f, w_bit})
                    2'b00: begin
                        dec_next.clk_min = AIDT_CLK_MPY_RB_MIN;
                        dec_next.clk_max = AIDT_CLK_MPY_RB_MAX;
                    end
                    2'b01: begin
                        dec_next.clk_min = AIDT_CLK_MPY_RW_MIN;
                        dec_next.clk_max = AIDT_CLK_MPY_RW_MAX;
                    end
                    2'b10: begin
                        dec_next.clk_min = AIDT_CLK_MPY_MB_MIN;
                        dec_next.clk_max = AIDT_CLK_MPY_MB_MAX;
                    end
                    2'b11: begin
                        dec_next.clk_min = AIDT_CLK_MPY_MW_MIN;
                        dec_next.clk_max = AIDT_CLK_MPY_MW_MAX;
                    end
                endcase
            end else begin
                dec_next.known = 1'b0;
            end
        end else begin
            dec_next.is_word = 1'b0;
            dec_next.is_mem  = 1'b0;
            unique case (op)
                AIDT_OP_ASC_ADD: begin
                    dec_next.op      = AIDT_ALU_ASCII_ADD;
                    dec_next.clk_min = AIDT_CLK_ASC_ADD;
                end
                AIDT_OP_ASC_SUB: begin
                    dec_next.op      = AIDT_ALU_ASCII_SUB;
                    dec_next.clk_min = AIDT_CLK_ASC_SUB;
                end
                AIDT_OP_DEC_ADD: begin
                    dec_next.op      = AIDT_ALU_DECIMAL_ADD;
                    dec_next.clk_min = AIDT_CLK_DEC_ADJ;
                end
                AIDT_OP_DEC_SUB: begin
                    dec_next.op      = AIDT_ALU_DECIMAL_SUB;
                    dec_next.clk_min = AIDT_CLK_DEC_ADJ;
                end
                AIDT_OP_PFX_CODE, AIDT_OP_PFX_STACK,
                AIDT_OP_PFX_DATA, AIDT_OP_PFX_EXTRA: begin
                    dec_next.op      = AIDT_ALU_PREFIX;
                    dec_next.clk_min = AIDT_CLK_PREFIX;
                end
                default: begin
                    dec_next.known = 1'b0;
                end
            endcase
        end
        if (dec_next.clk_max == 6'h00) begin
            dec_next.clk_max = dec_next.clk_min;
        end
        if (dec_next.op != AIDT_ALU_ADD && dec_next.op != AIDT_ALU_ADC &&
            dec_next.op != AIDT_ALU_SUB && dec_next.op != AIDT_ALU_BORROW) begin
            dec_next.imm_bytes = 2'h0;
        end
    end

    // =========================================================================
    // Segment override state
    // =========================================================================
    // The override is held across the prefix and consumed by the next
    // instruction, so a stray prefix never leaks past one instruction.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_valid_reg <= 1'b0;
            pend_seg_reg   <= aidt_seg_t'(AIDT_SEG_NONE_RST);
        end else if (clk_en && fetch.valid) begin
            if (dec_next.op == AIDT_ALU_PREFIX) begin
                pend_valid_reg <= 1'b1;
                pend_seg_reg   <= aidt_seg_t'(op[4:3]);
            end else begin
                pend_valid_reg <= 1'b0;
            end
        end
    end

    // =========================================================================
    // Output registers
    // =========================================================================
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dec_reg <= '0;
            imm_reg <= 16'h0000;
        end else if (clk_en) begin
            dec_reg <= dec_next;
            imm_reg <= imm_next;
        end
    end

endmodule : aidt_decode

// ==== aidt_decode_asserts.sv ====
/* Concurrent checks on the ports of aidt_decode, attached by bind.
   Assumes one clock domain, clk_sys, with rst_n active low. */
`timescale 1ns/100ps
module aidt_decode_asserts
    import aidt_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         rst_n,
    input wire logic         clk_en,
    input wire aidt_fetch_t  fetch,
    input wire logic [7:0]   data_lo,
    input wire logic [7:0]   data_hi,
    input wire aidt_decode_t dec_reg,
    input wire logic [15:0]  imm_reg
);
    // =====================================================================
    // Helper terms
    // =====================================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic tk, pfx, rm_f, reg_m, una;
    assign tk    = clk_en && fetch.valid;
    assign pfx   = fetch.opcode inside {8'h2E, 8'h36, 8'h3E, 8'h26};
    assign rm_f  = tk && ((fetch.opcode & 8'hFC) inside {8'h00, 8'h10, 8'h28, 8'h18});
    assign reg_m = fetch.modrm[7:6] == 2'h3;
    assign una   = tk && (fetch.opcode & 8'hFE) == 8'hF6;
    // =====================================================================
    // Properties
    // =====================================================================
    property p_pfx;
        tk && pfx |=> dec_reg.op == AIDT_ALU_PREFIX && dec_reg.clk_min == 6'h02;
    endproperty
    a_pfx: assert property (p_pfx) else $error("prefix class or count wrong");
    property p_seg;
        tk && pfx ##1 tk |=> dec_reg.seg_valid && dec_reg.seg == $past(fetch.opcode[4:3], 2);
    endproperty
    a_seg: assert property (p_seg) else $error("segment override not applied");
    property p_rm;
        rm_f |=> dec_reg.clk_min == ($past(reg_m) ? 6'h03 : 6'h0A)
            && dec_reg.is_mem != $past(reg_m);
    endproperty
    a_rm: assert property (p_rm) else $error("operand form count wrong");
    property p_carry; rm_f |=> dec_reg.use_carry == $past(fetch.opcode[4]); endproperty
    a_carry: assert property (p_carry) else $error("carry use wrong");
    property p_width; rm_f |=> dec_reg.is_word == $past(fetch.opcode[0]); endproperty
    a_width: assert property (p_width) else $error("width bit not followed");
    property p_neg;
        una && fetch.modrm[5:3] == 3'h3 |=> dec_reg.op == AIDT_ALU_SIGN_CHANGE
            && dec_reg.clk_max == ($past(reg_m) ? 6'h03 : 6'h0A);
    endproperty
    a_neg: assert property (p_neg) else $error("sign change decode wrong");
    property p_mul;
        una && fetch.modrm[5:3] == 3'h4 |=> dec_reg.clk_max == dec_reg.clk_min + 6'h02
            && dec_reg.clk_min == 6'h1A + ($past(fetch.opcode[0]) ? 6'h09 : 6'h00)
                                  + ($past(reg_m) ? 6'h00 : 6'h06);
    endproperty
    a_mul: assert property (p_mul) else $error("multiply range wrong");
    property p_adj;
        tk && fetch.opcode inside {8'h37, 8'h3F, 8'h27, 8'h2F} |=> dec_reg.length == 2'h1
            && dec_reg.clk_min == ($past(fetch.opcode) == 8'h37 ? 6'h08
                                 : $past(fetch.opcode) == 8'h3F ? 6'h07 : 6'h04);
    endproperty
    a_adj: assert property (p_adj) else $error("adjust count wrong");
    property p_sext;
        tk && fetch.opcode == 8'h83 |=> imm_reg == {{8{$past(data_lo[7])}}, $past(data_lo)};
    endproperty
    a_sext: assert property (p_sext) else $error("immediate not sign extended");
    property p_word;
        tk && fetch.opcode == 8'h81 |=> imm_reg == {$past(data_hi), $past(data_lo)};
    endproperty
    a_word: assert property (p_word) else $error("word immediate not assembled");
    property p_hold;
        !clk_en |=> $stable(dec_reg) && $stable(imm_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while disabled");
    c_pair: cover property (tk && pfx ##1 tk);
    c_mul: cover property (una && fetch.modrm[5:3] == 3'h4 && !reg_m);
    c_hold: cover property (!clk_en [*3]);
endmodule : aidt_decode_asserts

bind aidt_decode aidt_decode_asserts i_aidt_decode_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(clk_en), .fetch(fetch), .data_lo(data_lo), .data_hi(data_hi),
    .dec_reg(dec_reg), .imm_reg(imm_reg));

// ==== aidt_prefetch_model.sv ====
/* Behavioural prefetch queue: presents one instruction while req is high.
   Assumes the bench paces requests; idle cycles model a slow queue. */
`timescale 1ns/100ps
module aidt_prefetch_model
    import aidt_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        req,
    input  wire logic [31:0] req_bytes,
    output aidt_fetch_t      fetch,
    output logic      [7:0]  data_lo,
    output logic      [7:0]  data_hi
);
    // =====================================================================
    // Queue output
    // =====================================================================
    // Idle bytes toggle every cycle so stale values are never mistaken for data.
    logic [31:0] last_reg = 32'h0;
    always_ff @(posedge clk_sys) begin
        last_reg <= {fetch.opcode, fetch.modrm, data_lo, data_hi};
    end
    always_comb begin
        {fetch, data_lo, data_hi} = req ? {1'b1, req_bytes} : {1'b0, ~last_reg};
    end
endmodule : aidt_prefetch_model

// ==== arith_instr_decode_timing_tb_top.sv ====
/* Self-checking bench for aidt_decode fed by the prefetch queue model.
   Assumes the package, checker and model are compiled first. */
`timescale 1ns/100ps
module arith_instr_decode_timing_tb_top;
    import aidt_pkg::*;
    logic         clk_sys, rst_n, clk_en, req;
    logic [31:0]  req_bytes;
    logic [7:0]   data_lo, data_hi;
    aidt_fetch_t  fetch;
    aidt_decode_t dec_reg;
    logic [15:0]  imm_reg;
    int           err_total, comparisons, cycles;

    aidt_prefetch_model i_aidt_prefetch_model (.clk_sys(clk_sys), .req(req),
        .req_bytes(req_bytes), .fetch(fetch), .data_lo(data_lo), .data_hi(data_hi));
    aidt_decode i_aidt_decode (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .fetch(fetch), .data_lo(data_lo), .data_hi(data_hi), .dec_reg(dec_reg),
        .imm_reg(imm_reg));

    // =====================================================================
    // Shared tasks
    // =====================================================================
    task automatic step(input logic [7:0] op, md, lo, hi);
        @(negedge clk_sys);
        {req, req_bytes} = {1'b1, op, md, lo, hi};
    endtask : step
    task automatic idle();
        @(negedge clk_sys);
        req = 1'b0;
    endtask : idle
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic chk_cls(input aidt_op_t op, input logic [5:0] mn, mx, input logic [1:0] len);
        chk(dec_reg.valid === 1'b1 && dec_reg.known === 1'b1 && dec_reg.op === op, "class");
        chk(dec_reg.clk_min === mn && dec_reg.clk_max === mx, "clock count");
        chk(dec_reg.length === len, "length");
    endtask : chk_cls
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic t_prefix();
        logic [7:0] pf[4] = '{8'h2E, 8'h36, 8'h3E, 8'h26};
        aidt_seg_t  sg[4] = '{AIDT_SEG_CODE, AIDT_SEG_STACK, AIDT_SEG_DATA, AIDT_SEG_EXTRA};
        for (int i = 0; i < 4; i++) begin
            step(pf[i], 8'h00, 8'h00, 8'h00);
            step(8'h01, 8'h06, 8'h00, 8'h00);
            chk_cls(AIDT_ALU_PREFIX, 6'h02, 6'h02, 2'h1);
            step(8'h00, 8'hC0, 8'h00, 8'h00);
            chk_cls(AIDT_ALU_ADD, 6'h0A, 6'h0A, 2'h2);
            chk(dec_reg.seg_valid === 1'b1 && dec_reg.seg === sg[i], "override");
            idle();
            chk(dec_reg.seg_valid === 1'b0, "override outlived one operand");
        end
    endtask : t_prefix
    task automatic t_rm_forms();
        logic [7:0] op[4] = '{8'h00, 8'h10, 8'h28, 8'h18};
        aidt_op_t   cl[4] = '{AIDT_ALU_ADD, AIDT_ALU_ADC, AIDT_ALU_SUB, AIDT_ALU_BORROW};
        logic [5:0] ck;
        for (int i = 0; i < 32; i++) begin
            ck = (i & 4) ? 6'h03 : 6'h0A;
            step(op[i / 8] | 8'(i % 4), (i & 4) ? 8'hC1 : 8'h46, 8'h00, 8'h00);
            idle();
            chk_cls(cl[i / 8], ck, ck, 2'h2);
            chk(dec_reg.is_word === i[0] && dec_reg.is_mem === !i[2], "width or mem");
            chk(dec_reg.use_carry === (i / 8 == 1 || i / 8 == 3), "carry use");
        end
    endtask : t_rm_forms
    task automatic t_unary();
        logic [5:0] mn[4] = '{6'h1A, 6'h23, 6'h20, 6'h29};
        logic [5:0] ck;
        for (int i = 0; i < 4; i++) begin
            ck = (i > 1) ? 6'h0A : 6'h03;
            step(8'hF6 | 8'(i % 2), (i > 1) ? 8'h18 : 8'hD8, 8'h00, 8'h00);
            step(8'hF6 | 8'(i % 2), (i > 1) ? 8'h20 : 8'hE0, 8'h00, 8'h00);
            chk_cls(AIDT_ALU_SIGN_CHANGE, ck, ck, 2'h2);
            idle();
            chk_cls(AIDT_ALU_MULU, mn[i], mn[i] + 6'h02, 2'h2);
            chk(dec_reg.is_word === i[0], "multiply width");
        end
    endtask : t_unary
    task automatic t_adjust();
        logic [7:0] op[4] = '{8'h37, 8'h3F, 8'h27, 8'h2F};
        aidt_op_t   cl[4] = '{AIDT_ALU_ASCII_ADD, AIDT_ALU_ASCII_SUB,
                              AIDT_ALU_DECIMAL_ADD, AIDT_ALU_DECIMAL_SUB};
        logic [5:0] ck[4] = '{6'h08, 6'h07, 6'h04, 6'h04};
        for (int i = 0; i < 4; i++) begin
            step(op[i], 8'hC0, 8'h00, 8'h00);
            idle();
            chk_cls(cl[i], ck[i], ck[i], 2'h1);
        end
    endtask : t_adjust
    task automatic t_imm();
        step(8'h83, 8'hC0, 8'h80, 8'h55);
        step(8'h81, 8'hC0, 8'h34, 8'h12);
        chk(imm_reg === 16'hFF80 && dec_reg.imm_bytes === 2'h1, "sign extend");
        chk(dec_reg.imm_sext === 1'b1, "sign extend flag");
        step(8'h80, 8'h2F, 8'h80, 8'h55);
        chk(imm_reg === 16'h1234 && dec_reg.imm_bytes === 2'h2, "word data");
        idle();
        chk(imm_reg === 16'h0080 && dec_reg.is_word === 1'b0, "byte data");
        chk(dec_reg.op === AIDT_ALU_SUB && dec_reg.clk_min === 6'h10, "immediate memory");
        step(8'h81, 8'hC8, 8'h00, 8'h00);
        idle();
        chk(dec_reg.known === 1'b0 && dec_reg.clk_max === 6'h00, "outside opcode claimed");
    endtask : t_imm
    task automatic t_freeze();
        step(8'h37, 8'h00, 8'h00, 8'h00);
        step(8'h3F, 8'h00, 8'h00, 8'h00);
        clk_en = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk_cls(AIDT_ALU_ASCII_ADD, 6'h08, 6'h08, 2'h1);
        clk_en = 1'b1;
        idle();
        chk_cls(AIDT_ALU_ASCII_SUB, 6'h07, 6'h07, 2'h1);
        idle();
        chk(dec_reg.valid === 1'b0, "idle cycle marked valid");
    endtask : t_freeze
    task automatic t_reset();
        step(8'h36, 8'h00, 8'h00, 8'h00);
        idle();
        rst_n = 1'b0;
        @(negedge clk_sys);
        chk(dec_reg === '0 && imm_reg === 16'h0000, "reset values");
        rst_n = 1'b1;
        step(8'h00, 8'hC0, 8'h00, 8'h00);
        idle();
        chk(dec_reg.valid === 1'b1 && dec_reg.seg_valid === 1'b0, "override kept");
    endtask : t_reset

    // =====================================================================
    // Clock, reset, sequence and timeout
    // =====================================================================
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            $display("[FAIL] %0t run timed out", $time);
            final_report();
        end
    end
    initial begin
        {rst_n, clk_en, req, req_bytes} = {1'b0, 1'b1, 1'b0, 32'h0};
        repeat (10) @(negedge clk_sys);
        chk(dec_reg === '0 && imm_reg === 16'h0000, "reset values");
        rst_n = 1'b1;
        t_prefix();
        t_rm_forms();
        t_unary();
        t_adjust();
        t_imm();
        t_freeze();
        t_reset();
        final_report();
    end
endmodule : arith_instr_decode_timing_tb_top
